// ### design/lts_consts.svh
// Constants for the transmit shaping, idle monitor and loopback block
`ifndef LTS_CONSTS_SVH
`define LTS_CONSTS_SVH
`define LTS_NUM_CH 8
`define LTS_NUM_SEG 8
`define LTS_SEG_W 7
`define LTS_SEG_RESET 7'h00
`define LTS_IDLE_LIMIT 128
`define LTS_PRBS_SEED 15'h7fff
`define LTS_ADDR_W 8
// Segment word addresses: 0x00..0x3f = channel*8 + segment
`define LTS_ADDR_SEG_TOP 8'h3f
`define LTS_ADDR_CTRL_BASE 8'h40
`define LTS_ADDR_STAT_BASE 8'h48
`define LTS_ADDR_GSTAT 8'h50
// Control register fields
`define LTS_CTRL_LOOP_LSB 0
`define LTS_CTRL_TRI_BIT 3
`define LTS_CTRL_AOS_BIT 4
`define LTS_CTRL_PRBS_BIT 5
`define LTS_CTRL_IEN_BIT 6
`define LTS_CTRL_RESET 8'h00
// Status register fields
`define LTS_STAT_IDLE_BIT 0
`define LTS_STAT_LOSS_BIT 1
`define LTS_STAT_IDLE_CHG_BIT 2
`endif

// ### design/lts_pkg.sv
// Types for the transmit shaping, idle monitor and loopback block
package lts_pkg;
	typedef enum logic [2:0] {
		LTS_LOOP_NONE,
		LTS_LOOP_LOCAL,
		LTS_LOOP_REMOTE,
		LTS_LOOP_DIGITAL,
		LTS_LOOP_DUAL
	} lts_loop_t;
	typedef enum logic [1:0] {
		LTS_SEG_IDLE,
		LTS_SEG_RUN
	} lts_seg_state_t;
endpackage

// ### design/lts_idle_mon.sv
// Per-channel driver idle monitor
`timescale 1ns/1ns
`include "lts_consts.svh"
module lts_idle_mon #(
	parameter int LIMIT = `LTS_IDLE_LIMIT
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic pulse_i,
	output logic alarm_o
);
	localparam int CW = $clog2(LIMIT + 1);
	logic [CW-1:0] count;

	if (LIMIT < 2) begin : g_bad_limit
		$error("LIMIT too small");
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			count <= '0;
		end else if (pulse_i) begin
			count <= '0;
		end else if (count != CW'(LIMIT)) begin
			count <= count + 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			alarm_o <= 1'b0;
		end else if (pulse_i) begin
			alarm_o <= 1'b0;
		end else if (count == CW'(LIMIT)) begin
			alarm_o <= 1'b1;
		end
	end
endmodule

// ### design/lts_top.sv
// Eight-channel transmit shaping, idle monitor and loopback routing
`timescale 1ns/1ns
`include "lts_consts.svh"
module lts_top
	import lts_pkg::*;
#(
	parameter int NUM_CH = `LTS_NUM_CH,
	parameter int IDLE_LIMIT = `LTS_IDLE_LIMIT
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic [NUM_CH-1:0] tx_sys_pos_i,
	input wire logic [NUM_CH-1:0] tx_sys_neg_i,
	input wire logic [NUM_CH-1:0] rx_line_pos_i,
	input wire logic [NUM_CH-1:0] rx_line_neg_i,
	input wire logic [NUM_CH-1:0] rx_signal_loss_i,
	output logic [NUM_CH-1:0] tx_line_pos_o,
	output logic [NUM_CH-1:0] tx_line_neg_o,
	output logic [NUM_CH-1:0] tx_line_oe_o,
	output logic [NUM_CH*`LTS_SEG_W-1:0] tx_dac_o,
	output logic [NUM_CH-1:0] rx_sys_pos_o,
	output logic [NUM_CH-1:0] rx_sys_neg_o,
	output logic rx_signal_loss_o,
	output logic driver_idle_alarm_o,
	output logic irq_n_o
);
	localparam int NS = `LTS_NUM_SEG;
	localparam int SW = `LTS_SEG_W;

	// Parameter checks at elaboration
	if (NUM_CH < 1 || NUM_CH > 8) begin : g_bad_ch
		$error("NUM_CH must be 1 to 8");
	end
	if (IDLE_LIMIT < 2) begin : g_bad_limit
		$error("IDLE_LIMIT too small");
	end

	logic [SW-1:0] seg_word [NUM_CH*NS];
	logic [7:0] ctrl [NUM_CH];
	logic [NUM_CH-1:0] idle_chg;
	logic [NUM_CH-1:0] idle_prev;
	logic [NUM_CH-1:0] idle_alarm;
	logic [NUM_CH-1:0] pulse_seen;
	logic [NUM_CH-1:0] tx_pos;
	logic [NUM_CH-1:0] tx_neg;
	logic [NUM_CH-1:0] loop_rx_pos;
	logic [NUM_CH-1:0] loop_rx_neg;
	logic [NUM_CH-1:0] stat_rd;
	// Tristate select and held pulse polarity per channel
	logic [NUM_CH-1:0] tri_sel;
	logic [NUM_CH-1:0] seg_neg;
	logic [2:0] seg_idx [NUM_CH];
	lts_seg_state_t seg_state [NUM_CH];
	logic [14:0] prbs;
	logic [7:0] next_rdata;

	// Shared pseudo-random source for diagnostic pattern
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			prbs <= `LTS_PRBS_SEED;
		end else begin
			prbs <= {prbs[13:0], prbs[14] ^ prbs[13]};
		end
	end

	// Segment words, one per channel and segment
	genvar gs;
	generate
		for (gs = 0; gs < NUM_CH*NS; gs++) begin : g_seg
			always_ff @(posedge sys_clk_i or posedge rst_i) begin
				if (rst_i) begin
					seg_word[gs] <= `LTS_SEG_RESET;
				end else if (wr_i && addr_i == 8'(gs)) begin
					seg_word[gs] <= wdata_i[SW-1:0];
				end
			end
		end
	endgenerate

	genvar gc;
	generate
		for (gc = 0; gc < NUM_CH; gc++) begin : g_ch
			lts_loop_t mode;
			logic src_pos;
			logic src_neg;
			logic sel_pos;
			logic sel_neg;
			logic ctrl_wr;
			logic dac_neg;
			logic [SW-1:0] seg_cur;
			assign tri_sel[gc] = ctrl[gc][`LTS_CTRL_TRI_BIT];
			assign ctrl_wr = wr_i && addr_i == 8'(`LTS_ADDR_CTRL_BASE + gc);
			assign mode = lts_loop_t'(ctrl[gc][`LTS_CTRL_LOOP_LSB +: 3]);
			assign stat_rd[gc] = rd_i && addr_i == 8'(`LTS_ADDR_STAT_BASE + gc);

			always_ff @(posedge sys_clk_i or posedge rst_i) begin
				if (rst_i) begin
					ctrl[gc] <= `LTS_CTRL_RESET;
				end else if (ctrl_wr) begin
					ctrl[gc] <= wdata_i[2:0] > 3'd4 ? {wdata_i[7:3], 3'd0} : wdata_i;
				end
			end

			// Transmit source choice
			always_comb begin
				if (mode == LTS_LOOP_REMOTE || mode == LTS_LOOP_DUAL) begin
					src_pos = rx_line_pos_i[gc];
					src_neg = rx_line_neg_i[gc];
				end else begin
					src_pos = tx_sys_pos_i[gc];
					src_neg = tx_sys_neg_i[gc];
				end
				if (ctrl[gc][`LTS_CTRL_AOS_BIT]) begin
					sel_pos = ~prbs[gc % 2];
					sel_neg = prbs[gc % 2];
				end else if (ctrl[gc][`LTS_CTRL_PRBS_BIT]) begin
					sel_pos = prbs[14] & ~prbs[gc];
					sel_neg = prbs[14] & prbs[gc];
				end else begin
					sel_pos = src_pos & ~src_neg;
					sel_neg = src_neg & ~src_pos;
				end
			end
			assign tx_pos[gc] = sel_pos;
			assign tx_neg[gc] = sel_neg;
			assign pulse_seen[gc] = sel_pos | sel_neg;

			// Receive output choice
			always_comb begin
				case (mode)
					LTS_LOOP_LOCAL: begin
						loop_rx_pos[gc] = sel_pos;
						loop_rx_neg[gc] = sel_neg;
					end
					LTS_LOOP_DIGITAL, LTS_LOOP_DUAL: begin
						loop_rx_pos[gc] = tx_sys_pos_i[gc];
						loop_rx_neg[gc] = tx_sys_neg_i[gc];
					end
					default: begin
						loop_rx_pos[gc] = rx_line_pos_i[gc];
						loop_rx_neg[gc] = rx_line_neg_i[gc];
					end
				endcase
			end

			// Segment sequencer for return-to-zero shaping
			always_ff @(posedge sys_clk_i or posedge rst_i) begin
				if (rst_i) begin
					seg_state[gc] <= LTS_SEG_IDLE;
					seg_idx[gc] <= 3'd0;
					seg_neg[gc] <= 1'b0;
				end else begin
					case (seg_state[gc])
						LTS_SEG_IDLE: begin
							if (pulse_seen[gc]) begin
								seg_state[gc] <= LTS_SEG_RUN;
								seg_idx[gc] <= 3'd1;
								// Polarity held for the whole pulse
								seg_neg[gc] <= tx_neg[gc];
							end
						end
						LTS_SEG_RUN: begin
							seg_idx[gc] <= seg_idx[gc] + 3'd1;
							if (seg_idx[gc] == 3'(NS - 1)) begin
								seg_state[gc] <= LTS_SEG_IDLE;
							end
						end
						default: begin
							seg_state[gc] <= LTS_SEG_IDLE;
						end
					endcase
				end
			end

			// Current segment word and polarity of the pulse in progress
			assign seg_cur = seg_word[gc*NS + 32'(seg_idx[gc])];
			assign dac_neg = seg_state[gc] == LTS_SEG_RUN ? seg_neg[gc] : tx_neg[gc];

			// Word sent to shaping converter: sign in top bit, magnitude below
			always_ff @(posedge sys_clk_i or posedge rst_i) begin
				if (rst_i) begin
					tx_dac_o[gc*SW +: SW] <= `LTS_SEG_RESET;
				end else if (seg_state[gc] == LTS_SEG_RUN || pulse_seen[gc]) begin
					// Negative mark inverts sign bit; full magnitude stays full rail
					tx_dac_o[gc*SW +: SW] <= {seg_cur[SW-1] ^ dac_neg, seg_cur[SW-2:0]};
				end else begin
					tx_dac_o[gc*SW +: SW] <= `LTS_SEG_RESET;
				end
			end

			lts_idle_mon #(
				.LIMIT(IDLE_LIMIT)
			) u_idle (
				.sys_clk_i(sys_clk_i),
				.rst_i(rst_i),
				.pulse_i(pulse_seen[gc] & ~tri_sel[gc]),
				.alarm_o(idle_alarm[gc])
			);

			// Sticky change flag; a new change wins over the read clear
			always_ff @(posedge sys_clk_i or posedge rst_i) begin
				if (rst_i) begin
					idle_prev[gc] <= 1'b0;
					idle_chg[gc] <= 1'b0;
				end else begin
					idle_prev[gc] <= idle_alarm[gc];
					if (idle_alarm[gc] != idle_prev[gc]) begin
						idle_chg[gc] <= 1'b1;
					end else if (stat_rd[gc]) begin
						idle_chg[gc] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// Registered line outputs; a floated pair carries no marks
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_line_pos_o <= '0;
			tx_line_neg_o <= '0;
			tx_line_oe_o <= '0;
		end else begin
			tx_line_pos_o <= tx_pos & ~tri_sel;
			tx_line_neg_o <= tx_neg & ~tri_sel;
			tx_line_oe_o <= ~tri_sel;
		end
	end

	// Registered system receive outputs
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_sys_pos_o <= '0;
			rx_sys_neg_o <= '0;
		end else begin
			rx_sys_pos_o <= loop_rx_pos;
			rx_sys_neg_o <= loop_rx_neg;
		end
	end

	// Global alarms
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_signal_loss_o <= 1'b0;
			driver_idle_alarm_o <= 1'b0;
		end else begin
			rx_signal_loss_o <= |rx_signal_loss_i;
			driver_idle_alarm_o <= |idle_alarm;
		end
	end

	// Interrupt, low while any enabled channel holds a change
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_n_o <= 1'b1;
		end else begin
			irq_n_o <= 1'b1;
			for (int i = 0; i < NUM_CH; i++) begin
				if (idle_chg[i] && ctrl[i][`LTS_CTRL_IEN_BIT]) begin
					irq_n_o <= 1'b0;
				end
			end
		end
	end

	// Read data
	always_comb begin
		next_rdata = 8'h00;
		if (addr_i <= `LTS_ADDR_SEG_TOP) begin
			if (32'(addr_i) < NUM_CH*NS) begin
				next_rdata = {1'b0, seg_word[32'(addr_i)]};
			end
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (addr_i == 8'(`LTS_ADDR_CTRL_BASE + i)) begin
					next_rdata = ctrl[i];
				end
				if (addr_i == 8'(`LTS_ADDR_STAT_BASE + i)) begin
					next_rdata[`LTS_STAT_IDLE_BIT] = idle_alarm[i];
					next_rdata[`LTS_STAT_LOSS_BIT] = rx_signal_loss_i[i];
					next_rdata[`LTS_STAT_IDLE_CHG_BIT] = idle_chg[i];
				end
			end
			if (addr_i == `LTS_ADDR_GSTAT) begin
				next_rdata = 8'(idle_alarm);
			end
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			rdata_o <= next_rdata;
		end else begin
			rdata_o <= 8'h00;
		end
	end
endmodule

// ### test/lts_line_model.sv
// Line pair model for channel zero
`timescale 1ns/1ns
module lts_line_model (
	input wire logic sys_clk_i,
	input wire logic send_i,
	input wire logic tx_pos_i,
	input wire logic tx_neg_i,
	input wire logic tx_oe_i,
	output logic rx_pos_o,
	output logic rx_neg_o,
	output int marks_o
);
	initial marks_o = 0;
	// Receivers stay terminated; no impedance swap on this card
	// Quiet line carries no marks
	always_comb rx_pos_o = send_i;
	always_comb rx_neg_o = 1'b0;
	// Only driven pulses reach the line
	always @(posedge sys_clk_i) begin
		if (tx_oe_i && (tx_pos_i || tx_neg_i))
			marks_o <= marks_o + 1;
	end
endmodule

// ### test/lts_top_assertions.sv
// Port checker for the shaping and loopback block
`timescale 1ns/1ns
module lts_top_assertions #(
	parameter int NUM_CH = 8,
	parameter int IDLE_LIMIT = 128
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic [NUM_CH-1:0] rx_signal_loss_i,
	input wire logic [NUM_CH-1:0] tx_line_pos_o,
	input wire logic [NUM_CH-1:0] tx_line_neg_o,
	input wire logic [NUM_CH-1:0] tx_line_oe_o,
	input wire logic rx_signal_loss_o,
	input wire logic driver_idle_alarm_o,
	input wire logic irq_n_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	wire logic mark = |(tx_line_pos_o | tx_line_neg_o);
	AST_RDATA_IDLE: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data outside read slot");
	AST_UNMAPPED: assert property (rd_i && addr_i > 8'h50 |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	AST_LOSS_SET: assert property (|rx_signal_loss_i |=> rx_signal_loss_o)
		else $error("global loss missing");
	AST_LOSS_CLR: assert property (!(|rx_signal_loss_i) |=> !rx_signal_loss_o)
		else $error("global loss stuck");
	AST_RZ_MARK: assert property (!(|(tx_line_pos_o & tx_line_neg_o)))
		else $error("both rails marked");
	AST_TRI_QUIET: assert property (!(|((tx_line_pos_o | tx_line_neg_o) & ~tx_line_oe_o)))
		else $error("mark while floating");
	AST_IDLE_HOLD: assert property (driver_idle_alarm_o && !mark |=> driver_idle_alarm_o || mark)
		else $error("idle alarm dropped without pulse");
	AST_IRQ_RELEASE: assert property ($rose(irq_n_o) |-> $past(rd_i) || $past(rd_i, 2) || $past(wr_i) || $past(wr_i, 2))
		else $error("interrupt released without access");
	cover property ($rose(driver_idle_alarm_o));
	cover property ($fell(irq_n_o));
	cover property ($rose(rx_signal_loss_o));
endmodule
bind lts_top lts_top_assertions #(.NUM_CH(NUM_CH), .IDLE_LIMIT(IDLE_LIMIT)) u_chk (.sys_clk_i(sys_clk_i),
	.rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_signal_loss_i(rx_signal_loss_i),
	.tx_line_pos_o(tx_line_pos_o), .tx_line_neg_o(tx_line_neg_o), .tx_line_oe_o(tx_line_oe_o),
	.rx_signal_loss_o(rx_signal_loss_o), .driver_idle_alarm_o(driver_idle_alarm_o), .irq_n_o(irq_n_o));

// ### test/lts_top_test.sv
// Self-checking bench for the shaping, idle monitor and loopback block
`timescale 1ns/1ns
module lts_top_test;
	import lts_pkg::*;
	typedef struct packed {logic [7:0] ctrl; logic ts; logic rl; logic etl; logic ers;} lts_row_t;
	lts_row_t rows[6] = '{{8'h00, 1'b1, 1'b0, 1'b1, 1'b0}, {8'h01, 1'b1, 1'b0, 1'b1, 1'b1},
		{8'h02, 1'b0, 1'b1, 1'b1, 1'b1}, {8'h03, 1'b1, 1'b0, 1'b1, 1'b1},
		{8'h03, 1'b0, 1'b1, 1'b0, 1'b0}, {8'h04, 1'b1, 1'b0, 1'b0, 1'b1}};
	logic sys_clk_i, rst_i, wr_i, rd_i, send, mp, mn, los, dia, irq_n;
	logic [7:0] addr_i, wdata_i, rdata_o, rd, tsp, tsn, loss, tlp, tln, toe, rsp, rsn;
	logic [55:0] dac;
	int num_errors = 0;
	int compares = 0;
	int marks, mk;
	lts_top #(.IDLE_LIMIT(4)) dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tx_sys_pos_i(tsp), .tx_sys_neg_i(tsn),
		.rx_line_pos_i({7'h00, mp}), .rx_line_neg_i({7'h00, mn}), .rx_signal_loss_i(loss),
		.tx_line_pos_o(tlp), .tx_line_neg_o(tln), .tx_line_oe_o(toe), .tx_dac_o(dac), .rx_sys_pos_o(rsp),
		.rx_sys_neg_o(rsn), .rx_signal_loss_o(los), .driver_idle_alarm_o(dia), .irq_n_o(irq_n));
	lts_line_model line (.sys_clk_i(sys_clk_i), .send_i(send), .tx_pos_i(tlp[0]), .tx_neg_i(tln[0]),
		.tx_oe_i(toe[0]), .rx_pos_o(mp), .rx_neg_o(mn), .marks_o(marks));
	initial begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1 rd = rdata_o;
	endtask
	task automatic print_verdict;
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#20000;
		num_errors++;
		print_verdict;
	end
	initial begin
		{rst_i, wr_i, rd_i, send} = 4'h8;
		{addr_i, wdata_i, tsp, tsn, loss} = '0;
		tick(2);
		#1 chk({irq_n, rdata_o, tlp, toe, dia}, {1'b1, 25'h0});
		tick(1);
		rst_i <= 1'b0;
		@(posedge sys_clk_i) tsp <= 8'h01;
		@(posedge sys_clk_i) tsp <= 8'h00;
		#1 chk({tlp[0], dac[6:0]}, 8'h80);
		$display("reset test done");
		foreach (rows[i]) begin
			wr(8'h40, rows[i].ctrl);
			@(posedge sys_clk_i);
			tsp <= {7'h00, rows[i].ts};
			send <= rows[i].rl;
			tick(3);
			#1 chk({tlp[0], rsp[0]}, {rows[i].etl, rows[i].ers});
			$display("row %0d done", i);
		end
		tsp <= 8'h00;
		send <= 1'b0;
		wr(8'h40, 8'h00);
		wr(8'h00, 8'h7f);
		wr(8'h01, 8'h45);
		for (int p = 0; p < 2; p++) begin
			@(posedge sys_clk_i);
			tsp <= {7'h00, p[0]};
			tsn <= {7'h00, !p[0]};
			@(posedge sys_clk_i);
			tsp <= 8'h00;
			tsn <= 8'h00;
			#1 chk(dac[6:0], p ? 7'h7f : 7'h3f);
			@(posedge sys_clk_i);
			#1 chk(dac[6:0], p ? 7'h45 : 7'h05);
			tick(8);
		end
		$display("shaping test done");
		@(posedge sys_clk_i) tsp <= 8'h01;
		tick(2);
		tsp <= 8'h00;
		rdr(8'h50);
		chk(rd[0], 1'b0);
		tick(8);
		rdr(8'h50);
		chk({rd[0], dia}, 2'b11);
		rdr(8'h49);
		chk(rd[2:0], 3'b101);
		wr(8'h41, 8'h40);
		tick(2);
		#1 chk(irq_n, 1'b1);
		@(posedge sys_clk_i) tsp <= 8'h02;
		@(posedge sys_clk_i) tsp <= 8'h00;
		tick(12);
		#1 chk(irq_n, 1'b0);
		rdr(8'h49);
		chk(rd[2:0], 3'b101);
		tick(2);
		#1 chk(irq_n, 1'b1);
		rdr(8'h49);
		chk(rd[2], 1'b0);
		$display("idle test done");
		wr(8'h41, 8'h08);
		tsp <= 8'h02;
		tick(3);
		#1 chk({toe[1], tlp[1]}, 2'b00);
		tsp <= 8'h00;
		wr(8'h40, 8'h13);
		send <= 1'b1;
		tick(4);
		#1 mk = marks;
		tick(8);
		#1 chk(marks - mk, 8);
		chk(rsp[0], 1'b0);
		wr(8'h40, 8'h23);
		send <= 1'b0;
		tick(2);
		#1 mk = marks;
		tick(16);
		#1 chk(marks - mk > 0 && marks - mk < 16, 1'b1);
		$display("pattern test done");
		loss <= 8'h20;
		tick(2);
		#1 chk(los, 1'b1);
		rdr(8'h4d);
		chk(rd[1], 1'b1);
		loss <= 8'h00;
		wr(8'h60, 8'hff);
		rdr(8'h60);
		chk(rd, 8'h00);
		$display("status test done");
		rst_i <= 1'b1;
		tick(2);
		rst_i <= 1'b0;
		rdr(8'h00);
		chk(rd, 8'h00);
		$display("mid-run reset test done");
		print_verdict;
	end
endmodule
